// ==== shared/trm_pkg.sv ====
// Constants, register map and types for the temperature readout block
`default_nettype none
package trm_pkg;
	// Register offsets (pointer values)
	localparam logic [7:0] REG_CONFIG2      = 8'h01;
	localparam logic [7:0] REG_STATUS1      = 8'h02;
	localparam logic [7:0] REG_STATUS2      = 8'h03;
	localparam logic [7:0] REG_EXT_FRAC     = 8'h06;
	localparam logic [7:0] REG_LOCAL_TEMP   = 8'h0a;
	localparam logic [7:0] REG_REMOTE_TEMP  = 8'h0b;
	localparam logic [7:0] REG_LOCAL_HIGH   = 8'h10;
	localparam logic [7:0] REG_LOCAL_LOW    = 8'h11;
	localparam logic [7:0] REG_LOCAL_OT     = 8'h12;
	localparam logic [7:0] REG_REMOTE_HIGH  = 8'h14;
	localparam logic [7:0] REG_REMOTE_LOW   = 8'h15;
	localparam logic [7:0] REG_REMOTE_OT    = 8'h16;
	localparam logic [7:0] REG_OT_BEHAV     = 8'h3f;
	// Field positions
	localparam int CFG2_REMOTE_EN = 2;
	localparam int CFG2_LOCAL_EN  = 3;
	localparam int ST1_RHIGH      = 2;
	localparam int ST1_RLOW       = 3;
	localparam int ST1_ROT        = 4;
	localparam int ST1_LHIGH      = 6;
	localparam int ST1_LLOW       = 7;
	localparam int ST2_LOT        = 6;
	localparam int ST2_EXT_PULL   = 7;
	localparam int OTB_FAN_EN     = 7;
	localparam int EXT_REM_LSB    = 5;
	localparam int EXT_LOC_LSB    = 3;
	// Reset values
	localparam logic [7:0] CONFIG2_RST = 8'h0c;
	localparam logic [7:0] HIGH_RST    = 8'h46;
	localparam logic [7:0] LOW_RST     = 8'h80;
	localparam logic [7:0] OT_RST      = 8'h50;
	localparam logic [7:0] TEMP_RST    = 8'h00;
	// Revision code: value is arbitrary
	localparam logic [6:0] REVISION    = 7'h01;
	// Hysteresis on the overtemperature release, whole degrees
	localparam logic [8:0] OT_HYST_DEG = 9'h005;
	// Address select decode
	localparam logic [1:0] ADDR_LSB_GND  = 2'h0;
	localparam logic [1:0] ADDR_LSB_OPEN = 2'h2;
	localparam logic [1:0] ADDR_LSB_VCC  = 2'h1;
	// Averaging and conversion time
	localparam int          AVG_COUNT     = 16;
	localparam logic [3:0]  AVG_LAST      = 4'hf;
	localparam real         CLK_MHZ       = 125.0;
	localparam real         REMOTE_CONV_MS = 9.6;
	localparam int REMOTE_CONV_CYC = $rtoi(REMOTE_CONV_MS * 1000.0 * CLK_MHZ);
	localparam logic [1:0]  SYNC_FILL     = 2'h2;

	typedef struct packed {
		logic [7:0] whole;
		logic [2:0] frac;
	} trm_temp_t;

	typedef enum {AVG_WAIT, AVG_SAMPLE} trm_avg_state_t;
endpackage
`default_nettype wire

// ==== rtl/trm_readout_alert.sv ====
// Temperature result formatting, limit compare, alert and overtemp pin
// Function
// - Remote result weighs 0.125 degree per LSB, span -128 to +127.875.
// - Integer bytes are eight-bit two's complement whole degrees.
// - Remote fraction is three bits of 0.125 degree below the integer.
// - Local fraction is two bits of 0.25 degree.
// - Both fractions are readable together in register 0x06.
// - Remote conversion yields eleven-bit two's complement, split integer/frac.
// - Remote value is the average of sixteen measurements.
// - One remote result takes nominally 9.6 ms.
// - Address select pin sampled once at power-up, sets address LSBs.
// - Alert goes low below the low limit unless channel disabled.
// - Alert goes low above the high limit unless channel disabled.
// - Overtemp pin goes low above the overtemperature limit.
// - Overtemp pin is unmaskable; alert is maskable per channel.
// - Fan-force enable clear: own overtemp drive does not force fan.
// - Fan-force enable set: fan full while device drives overtemp.
// - External pull low sets status 2 bit 7 and forces fan, only while the device is not driving the pin itself.
// - Overtemp pin is open-drain; device only pulls low or releases.
// - Clearing a channel enable clears its pending status and masks it.
// - High and overtemperature limits are compared independently.
// - Alert released after alert-response read, reasserted at the next conversion end.
// - Reading status clears limit bits; they set again if still true.
// - Overtemp stays low until temperature is more than 5 degrees below limit.
`timescale 1ns/10ps
`default_nettype none
module trm_readout_alert
	import trm_pkg::*;
#(
	parameter int REMOTE_CONV_CYCLES = REMOTE_CONV_CYC
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Register access from the serial bus engine
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output var  logic [7:0]  reg_rdata,
	input  wire logic        ara_done,
	// Converter
	input  wire logic        local_valid,
	input  wire logic [9:0]  local_sample,
	input  wire logic        remote_valid,
	input  wire logic [10:0] remote_sample,
	output var  logic        remote_req,
	// Address select pin, decoded
	input  wire logic        addr_sel_vcc,
	input  wire logic        addr_sel_open,
	output var  logic [1:0]  addr_lsb,
	// Overtemperature pin and outputs
	input  wire logic        overtemp_io_n_i,
	output var  logic        overtemp_io_n_o,
	output var  logic        overtemp_io_n_oe,
	output var  logic        alert_n,
	output var  logic        fan_full
);
	localparam int MEAS_CYCLES = REMOTE_CONV_CYCLES / AVG_COUNT;
	localparam logic [31:0] MEAS_LAST = 32'(MEAS_CYCLES - 1);
	function automatic logic above(input logic [7:0] t, input logic [7:0] l);
		return $signed(t) > $signed(l);
	endfunction
	function automatic logic below(input logic [7:0] t, input logic [7:0] l);
		return $signed(t) < $signed(l);
	endfunction
	function automatic logic ot_release(input logic [7:0] t, l);
		return $signed({t[7], t}) < $signed({l[7], l} - OT_HYST_DEG);
	endfunction
	// Registers
	logic [7:0]     cfg2_r;
	logic [7:0]     st1_r;
	logic [7:0]     st2_r;
	logic [7:0]     loc_high_r, loc_low_r, loc_ot_r;
	logic [7:0]     rem_high_r, rem_low_r, rem_ot_r;
	logic           fan_en_r;
	trm_temp_t      loc_r, rem_r;
	logic [7:0]     rdata_r;
	// Averaging
	trm_avg_state_t avg_state_r;
	logic [31:0]    meas_cnt_r;
	logic [3:0]     avg_cnt_r;
	logic [14:0]    acc_r, acc_nxt;
	logic           req_r;
	logic           rem_done, loc_done;
	trm_temp_t      rem_nxt, loc_nxt;
	// Pins
	logic           ot_s1_r, ot_s2_r;
	logic           vcc_s1_r, vcc_s2_r, open_s1_r, open_s2_r;
	logic [1:0]     fill_r;
	logic           cap_done_r;
	logic [1:0]     addr_r;
	logic           drv_r, drv_d1_r, drv_d2_r, ext_low;
	logic           ot_rem_r, ot_loc_r, fan_r, alert_n_r, hold_r;
	logic           rem_en, loc_en, st1_rd, st2_rd;
	logic [7:0]     st1_set, st2_set;
	assign rem_en = cfg2_r[CFG2_REMOTE_EN];
	assign loc_en = cfg2_r[CFG2_LOCAL_EN];
	assign st1_rd = reg_rd && (reg_addr == REG_STATUS1);
	assign st2_rd = reg_rd && (reg_addr == REG_STATUS2);
	// Remote averaging: sixteen samples, one every MEAS_CYCLES
	assign acc_nxt = acc_r + {{4{remote_sample[10]}}, remote_sample};
	assign rem_done = (avg_state_r == AVG_SAMPLE) && remote_valid &&
	                  (avg_cnt_r == AVG_LAST);
	assign rem_nxt = trm_temp_t'(acc_nxt[14:4]);
	assign loc_done = local_valid;
	assign loc_nxt = '{whole: local_sample[9:2],
	                   frac: {local_sample[1:0], 1'b0}};
	always_ff @(posedge clk) begin
		if (reset) begin
			avg_state_r <= AVG_WAIT;
			meas_cnt_r <= '0;
			avg_cnt_r <= '0;
			acc_r <= '0;
			req_r <= 1'b0;
		end else begin
			req_r <= 1'b0;
			case (avg_state_r)
				AVG_WAIT: begin
					if (meas_cnt_r >= MEAS_LAST) begin
						meas_cnt_r <= '0;
						req_r <= 1'b1;
						avg_state_r <= AVG_SAMPLE;
					end else begin
						meas_cnt_r <= meas_cnt_r + 32'h1;
					end
				end
				AVG_SAMPLE: begin
					// Timer keeps running so the period stays fixed
					meas_cnt_r <= meas_cnt_r + 32'h1;
					if (remote_valid) begin
						avg_cnt_r <= avg_cnt_r + 4'h1;
						acc_r <= (avg_cnt_r == AVG_LAST) ? '0 : acc_nxt;
						avg_state_r <= AVG_WAIT;
					end
				end
				default: avg_state_r <= AVG_WAIT;
			endcase
		end
	end
	// Results
	always_ff @(posedge clk) begin
		if (reset) begin
			rem_r <= '{whole: TEMP_RST, frac: 3'h0};
			loc_r <= '{whole: TEMP_RST, frac: 3'h0};
		end else begin
			if (rem_done)
				rem_r <= rem_nxt;
			if (loc_done)
				loc_r <= loc_nxt;
		end
	end
	// Software registers
	always_ff @(posedge clk) begin
		if (reset) begin
			cfg2_r <= CONFIG2_RST;
			loc_high_r <= HIGH_RST;
			loc_low_r <= LOW_RST;
			loc_ot_r <= OT_RST;
			rem_high_r <= HIGH_RST;
			rem_low_r <= LOW_RST;
			rem_ot_r <= OT_RST;
			fan_en_r <= 1'b0;
		end else if (reg_wr) begin
			case (reg_addr)
				REG_CONFIG2:     cfg2_r <= reg_wdata;
				REG_LOCAL_HIGH:  loc_high_r <= reg_wdata;
				REG_LOCAL_LOW:   loc_low_r <= reg_wdata;
				REG_LOCAL_OT:    loc_ot_r <= reg_wdata;
				REG_REMOTE_HIGH: rem_high_r <= reg_wdata;
				REG_REMOTE_LOW:  rem_low_r <= reg_wdata;
				REG_REMOTE_OT:   rem_ot_r <= reg_wdata;
				REG_OT_BEHAV:    fan_en_r <= reg_wdata[OTB_FAN_EN];
				default:         ;
			endcase
		end
	end
	// Status set terms, evaluated at conversion ends except the external-pull bit
	always_comb begin
		st1_set = '0;
		st2_set = '0;
		st1_set[ST1_RHIGH] = rem_done && rem_en &&
		                     above(rem_nxt.whole, rem_high_r);
		st1_set[ST1_RLOW] = rem_done && rem_en &&
		                    below(rem_nxt.whole, rem_low_r);
		st1_set[ST1_ROT] = rem_done && rem_en &&
		                   above(rem_nxt.whole, rem_ot_r);
		st1_set[ST1_LHIGH] = loc_done && loc_en &&
		                     above(loc_nxt.whole, loc_high_r);
		st1_set[ST1_LLOW] = loc_done && loc_en &&
		                    below(loc_nxt.whole, loc_low_r);
		st2_set[ST2_LOT] = loc_done && loc_en &&
		                   above(loc_nxt.whole, loc_ot_r);
		st2_set[ST2_EXT_PULL] = ext_low;
	end
	// Read clears; a set in the same cycle wins
	always_ff @(posedge clk) begin
		if (reset) begin
			st1_r <= '0;
			st2_r <= '0;
		end else begin
			st1_r <= (st1_rd ? 8'h00 : st1_r) | st1_set;
			st2_r <= (st2_rd ? 8'h00 : st2_r) | st2_set;
			if (!rem_en) begin
				st1_r[ST1_RHIGH] <= 1'b0;
				st1_r[ST1_RLOW] <= 1'b0;
				st1_r[ST1_ROT] <= 1'b0;
			end
			if (!loc_en) begin
				st1_r[ST1_LHIGH] <= 1'b0;
				st1_r[ST1_LLOW] <= 1'b0;
				st2_r[ST2_LOT] <= 1'b0;
			end
		end
	end
	// Read data, one cycle after the strobe
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_r <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				REG_CONFIG2:     rdata_r <= cfg2_r;
				REG_STATUS1:     rdata_r <= st1_r;
				REG_STATUS2:     rdata_r <= st2_r;
				REG_EXT_FRAC:    rdata_r <= {rem_r.frac, loc_r.frac[2:1],
				                             3'h0};
				REG_LOCAL_TEMP:  rdata_r <= loc_r.whole;
				REG_REMOTE_TEMP: rdata_r <= rem_r.whole;
				REG_LOCAL_HIGH:  rdata_r <= loc_high_r;
				REG_LOCAL_LOW:   rdata_r <= loc_low_r;
				REG_LOCAL_OT:    rdata_r <= loc_ot_r;
				REG_REMOTE_HIGH: rdata_r <= rem_high_r;
				REG_REMOTE_LOW:  rdata_r <= rem_low_r;
				REG_REMOTE_OT:   rdata_r <= rem_ot_r;
				REG_OT_BEHAV:    rdata_r <= {fan_en_r, REVISION};
				default:         rdata_r <= 8'h00;
			endcase
		end
	end
	// Overtemperature latches, never masked, with release hysteresis
	always_ff @(posedge clk) begin
		if (reset) begin
			ot_rem_r <= 1'b0;
			ot_loc_r <= 1'b0;
		end else begin
			if (rem_done) begin
				if (above(rem_nxt.whole, rem_ot_r))
					ot_rem_r <= 1'b1;
				else if (ot_release(rem_nxt.whole, rem_ot_r))
					ot_rem_r <= 1'b0;
			end
			if (loc_done) begin
				if (above(loc_nxt.whole, loc_ot_r))
					ot_loc_r <= 1'b1;
				else if (ot_release(loc_nxt.whole, loc_ot_r))
					ot_loc_r <= 1'b0;
			end
		end
	end
	// Pin synchronisers
	always_ff @(posedge clk) begin
		if (reset) begin
			ot_s1_r <= 1'b1;
			ot_s2_r <= 1'b1;
			vcc_s1_r <= 1'b0;
			vcc_s2_r <= 1'b0;
			open_s1_r <= 1'b0;
			open_s2_r <= 1'b0;
		end else begin
			ot_s1_r <= overtemp_io_n_i;
			ot_s2_r <= ot_s1_r;
			vcc_s1_r <= addr_sel_vcc;
			vcc_s2_r <= vcc_s1_r;
			open_s1_r <= addr_sel_open;
			open_s2_r <= open_s1_r;
		end
	end
	// Own drive is blanked for the synchroniser delay; while driving,
	// an outside pull cannot be told apart
	assign ext_low = !ot_s2_r && !drv_r && !drv_d1_r && !drv_d2_r;
	always_ff @(posedge clk) begin
		if (reset) begin
			drv_r <= 1'b0;
			drv_d1_r <= 1'b0;
			drv_d2_r <= 1'b0;
			fan_r <= 1'b0;
		end else begin
			drv_r <= ot_rem_r || ot_loc_r;
			drv_d1_r <= drv_r;
			drv_d2_r <= drv_d1_r;
			fan_r <= ext_low || (fan_en_r && drv_r);
		end
	end
	// Address select captured once after reset release
	always_ff @(posedge clk) begin
		if (reset) begin
			fill_r <= '0;
			cap_done_r <= 1'b0;
			addr_r <= ADDR_LSB_GND;
		end else if (!cap_done_r) begin
			if (fill_r == SYNC_FILL) begin
				cap_done_r <= 1'b1;
				addr_r <= vcc_s2_r ? ADDR_LSB_VCC :
				          open_s2_r ? ADDR_LSB_OPEN : ADDR_LSB_GND;
			end else begin
				fill_r <= fill_r + 2'h1;
			end
		end
	end
	// Alert: pending enabled status, held off after alert-response read
	always_ff @(posedge clk) begin
		if (reset) begin
			hold_r <= 1'b0;
			alert_n_r <= 1'b1;
		end else begin
			if (rem_done || loc_done)
				hold_r <= 1'b0;
			else if (ara_done)
				hold_r <= 1'b1;
			alert_n_r <= !(((|st1_r) || st2_r[ST2_LOT]) && !hold_r);
		end
	end
	assign reg_rdata = rdata_r;
	assign remote_req = req_r;
	assign addr_lsb = addr_r;
	assign overtemp_io_n_o = 1'b0;
	assign overtemp_io_n_oe = drv_r;
	assign alert_n = alert_n_r;
	assign fan_full = fan_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_ara_quiet;
		ara_done && !(rem_done || loc_done) ##1 !(rem_done || loc_done);
	endsequence
	chk_ot_drive_set: assert property (rem_done &&
		above(rem_nxt.whole, rem_ot_r) |=> ##1 overtemp_io_n_oe)
		else $error("overtemp not driven after limit exceeded");
	chk_ot_hyst_hold: assert property (ot_rem_r && rem_done &&
		!ot_release(rem_nxt.whole, rem_ot_r) |=> ot_rem_r)
		else $error("overtemp released inside hysteresis");
	chk_fan_no_force: assert property (drv_r && !fan_en_r && !ext_low
		|=> !fan_full)
		else $error("fan forced with enable clear");
	chk_fan_force_on: assert property (drv_r && fan_en_r |=> fan_full)
		else $error("fan not forced while driving");
	chk_ext_pull_fan: assert property (ext_low
		|=> fan_full && st2_r[ST2_EXT_PULL])
		else $error("external pull not reported");
	chk_rem_high_set: assert property (rem_done && rem_en &&
		above(rem_nxt.whole, rem_high_r) |=> st1_r[ST1_RHIGH])
		else $error("remote high status missed");
	chk_rem_low_set: assert property (rem_done && rem_en &&
		below(rem_nxt.whole, rem_low_r) |=> st1_r[ST1_RLOW])
		else $error("remote low status missed");
	chk_mask_clears: assert property (!rem_en
		|=> !st1_r[ST1_RHIGH] && !st1_r[ST1_RLOW])
		else $error("disabled channel keeps status");
	chk_read_clears: assert property (st1_rd && !(|st1_set) && rem_en &&
		loc_en |=> st1_r == 8'h00)
		else $error("status not cleared by read");
	chk_ara_release: assert property (s_ara_quiet |=> alert_n)
		else $error("alert held after alert response");
	chk_avg_sixteen: assert property (rem_done |=> acc_r == '0)
		else $error("accumulator not restarted after result");
	chk_addr_frozen: assert property (cap_done_r |=> $stable(addr_lsb))
		else $error("address bits changed after capture");
endmodule
`default_nettype wire

// ==== verif/trm_partner.sv ====
// Converter and external overtemperature agent model
`timescale 1ns/10ps
`default_nettype none
module trm_partner
	import trm_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Converter side
	input  wire logic        remote_req,
	output var  logic        remote_valid,
	output var  logic [10:0] remote_sample,
	// Scenario controls
	input  wire logic        slow,
	input  wire logic        dither,
	input  wire logic [10:0] temp,
	input  wire logic        ext_pull,
	// Overtemperature pin
	input  wire logic        overtemp_io_n_oe,
	output var  logic        overtemp_io_n_i
);
	logic [2:0] wait_r;
	logic       busy_r;
	logic       odd_r;
	logic       fire;

	assign fire = busy_r && wait_r == 3'h0 && !remote_req;
	// Pull-up on the wire; each party may only pull it low
	assign overtemp_io_n_i = !(overtemp_io_n_oe || ext_pull);
	// One sample per request; a slow answer still lands inside the period
	always_ff @(posedge clk) begin
		if (reset) begin
			busy_r       <= 1'b0;
			wait_r       <= 3'h0;
			odd_r        <= 1'b0;
			remote_valid <= 1'b0;
		end else if (remote_req) begin
			busy_r       <= 1'b1;
			wait_r       <= slow ? 3'h3 : 3'h0;
			remote_valid <= 1'b0;
		end else if (fire) begin
			busy_r       <= 1'b0;
			odd_r        <= !odd_r;
			remote_valid <= 1'b1;
		end else begin
			if (wait_r != 3'h0)
				wait_r <= wait_r - 3'h1;
			remote_valid <= 1'b0;
		end
	end
	// Dither alternates base and base+2, so the mean is base+1
	always_ff @(posedge clk) begin
		if (reset)
			remote_sample <= 11'h555;
		else if (fire)
			remote_sample <= (dither && odd_r) ? temp + 11'h2 : temp;
		else
			remote_sample <= ~remote_sample;
	end
endmodule
`default_nettype wire

// ==== verif/trm_readout_alert_test.sv ====
// Self-checking bench for the temperature readout block
`timescale 1ns/10ps
`default_nettype none
module trm_readout_alert_test
	import trm_pkg::*;
;
	localparam int CONV = 160;
	logic        clk, reset, reg_wr, reg_rd, ara_done, local_valid;
	logic        remote_valid, remote_req, addr_sel_vcc, addr_sel_open;
	logic        io_i, io_o, io_oe, alert_n, fan_full, slow, dither;
	logic        ext_pull;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
	logic [9:0]  local_sample;
	logic [10:0] remote_sample, temp;
	logic [1:0]  addr_lsb;
	int          n_fail, check_count, n;

	trm_readout_alert #(.REMOTE_CONV_CYCLES(CONV)) u_dut (
		.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.ara_done(ara_done), .local_valid(local_valid),
		.local_sample(local_sample), .remote_valid(remote_valid),
		.remote_sample(remote_sample), .remote_req(remote_req),
		.addr_sel_vcc(addr_sel_vcc), .addr_sel_open(addr_sel_open),
		.addr_lsb(addr_lsb), .overtemp_io_n_i(io_i),
		.overtemp_io_n_o(io_o), .overtemp_io_n_oe(io_oe),
		.alert_n(alert_n), .fan_full(fan_full));
	trm_partner u_far (
		.clk(clk), .reset(reset), .remote_req(remote_req),
		.remote_valid(remote_valid), .remote_sample(remote_sample),
		.slow(slow), .dither(dither), .temp(temp), .ext_pull(ext_pull),
		.overtemp_io_n_oe(io_oe), .overtemp_io_n_i(io_i));

	task automatic results();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		tick(1);
		reg_addr = a;
		reg_rd = 1'b1;
		tick(1);
		reg_rd = 1'b0;
		rv = reg_rdata;
	endtask
	task automatic rdc(input logic [7:0] a, e);
		rd(a);
		chk($sformatf("reg %h", a), e, rv);
	endtask
	task automatic wr(input logic [7:0] a, d);
		tick(1);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick(1);
		reg_wr = 1'b0;
	endtask
	// Cycles until the next sample request, bounded
	task automatic wreq();
		n = 0;
		do begin
			tick(1);
			n++;
		end while (remote_req !== 1'b1 && n < 40);
		if (remote_req !== 1'b1) begin
			n_fail++;
			results();
		end
	endtask
	// Lands just after a sample's effects, well before the next one
	task automatic wconv();
		tick(2 * CONV);
		wreq();
		tick(8);
	endtask
	// One local result, settled on return
	task automatic lpulse(input logic [9:0] s);
		tick(1);
		local_sample = s;
		local_valid = 1'b1;
		tick(1);
		local_valid = 1'b0;
		tick(3);
	endtask

	task automatic t_reset();
		chk("addr", 8'(ADDR_LSB_OPEN), 8'(addr_lsb));
		addr_sel_vcc = 1'b1;
		tick(5);
		chk("addr held", 8'(ADDR_LSB_OPEN), 8'(addr_lsb));
		rdc(REG_CONFIG2, CONFIG2_RST);
		rdc(REG_REMOTE_HIGH, HIGH_RST);
		rdc(REG_REMOTE_LOW, LOW_RST);
		rdc(REG_LOCAL_OT, OT_RST);
		rdc(REG_OT_BEHAV, {1'b0, REVISION});
		rdc(8'h40, 8'h00);
		$display("test reset done");
	endtask
	task automatic t_remote();
		logic [10:0] base [2] = '{11'h0cc, 11'h7f6};
		logic [7:0]  whole[2] = '{8'h19, 8'hfe};
		logic [2:0]  frac [2] = '{3'h5, 3'h7};
		for (int i = 0; i < 2; i++) begin
			temp = base[i];
			wconv();
			rdc(REG_REMOTE_TEMP, whole[i]);
			rd(REG_EXT_FRAC);
			chk("rfrac", 8'(frac[i]), 8'(rv[7:5]));
		end
		slow = 1'b1;
		wreq();
		wreq();
		chk("req gap", 8'(CONV / AVG_COUNT), 8'(n));
		$display("test remote done");
	endtask
	task automatic t_local();
		logic [9:0] smp[2] = '{10'h067, 10'h3fd};
		logic [1:0] lf [2] = '{2'h3, 2'h1};
		logic [7:0] lw [2] = '{8'h19, 8'hff};
		for (int i = 0; i < 2; i++) begin
			lpulse(smp[i]);
			rdc(REG_LOCAL_TEMP, lw[i]);
			rd(REG_EXT_FRAC);
			chk("lfrac", 8'(lf[i]), 8'(rv[4:3]));
		end
		wr(REG_LOCAL_HIGH, 8'h10);
		wr(REG_LOCAL_OT, 8'h18);
		lpulse(smp[0]);
		chk("loc ot", 8'h1, 8'(io_oe));
		rdc(REG_STATUS1, 8'(1 << ST1_LHIGH));
		rdc(REG_STATUS2, 8'(1 << ST2_LOT));
		lpulse(smp[1]);
		chk("loc ot off", 8'h0, 8'(io_oe));
		wr(REG_LOCAL_HIGH, HIGH_RST);
		wr(REG_LOCAL_OT, OT_RST);
		$display("test local done");
	endtask
	task automatic t_limits();
		temp = 11'h0cc;
		wreq();
		wr(REG_REMOTE_HIGH, 8'h10);
		rdc(REG_STATUS1, 8'h00);
		chk("alert idle", 8'h1, 8'(alert_n));
		wconv();
		chk("alert high", 8'h0, 8'(alert_n));
		ara_done = 1'b1;
		tick(1);
		ara_done = 1'b0;
		tick(1);
		chk("alert ara", 8'h1, 8'(alert_n));
		wconv();
		chk("alert again", 8'h0, 8'(alert_n));
		rdc(REG_STATUS1, 8'(1 << ST1_RHIGH));
		rdc(REG_STATUS1, 8'h00);
		wr(REG_REMOTE_HIGH, HIGH_RST);
		wr(REG_REMOTE_LOW, 8'h1a);
		wconv();
		rdc(REG_STATUS1, 8'(1 << ST1_RLOW));
		wconv();
		chk("alert low", 8'h0, 8'(alert_n));
		wr(REG_CONFIG2, 8'h08);
		tick(3);
		chk("alert mask", 8'h1, 8'(alert_n));
		wconv();
		rdc(REG_STATUS1, 8'h00);
		wr(REG_REMOTE_LOW, LOW_RST);
		wr(REG_CONFIG2, CONFIG2_RST);
		$display("test limits done");
	endtask
	task automatic t_overtemp();
		wr(REG_REMOTE_OT, 8'h18);
		wconv();
		chk("ot oe", 8'h1, 8'(io_oe));
		chk("ot pin", 8'h0, 8'({io_o, io_i}));
		chk("fan off", 8'h0, 8'(fan_full));
		rdc(REG_STATUS1, 8'(1 << ST1_ROT));
		wr(REG_OT_BEHAV, 8'h80);
		tick(3);
		chk("fan on", 8'h1, 8'(fan_full));
		rdc(REG_OT_BEHAV, {1'b1, REVISION});
		wr(REG_CONFIG2, 8'h08);
		temp = 11'h0a2;
		wconv();
		chk("ot masked", 8'h1, 8'(io_oe));
		wr(REG_CONFIG2, CONFIG2_RST);
		temp = 11'h08e;
		wconv();
		chk("ot free", 8'h0, 8'({io_oe, fan_full}));
		wr(REG_OT_BEHAV, 8'h00);
		$display("test overtemp done");
	endtask
	task automatic t_extpull();
		rd(REG_STATUS2);
		ext_pull = 1'b1;
		tick(6);
		chk("fan pull", 8'h1, 8'(fan_full));
		ext_pull = 1'b0;
		rdc(REG_STATUS2, 8'(1 << ST2_EXT_PULL));
		$display("test extpull done");
	endtask

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		{reg_wr, reg_rd, ara_done, local_valid, addr_sel_vcc} = '0;
		{slow, dither, ext_pull, n_fail, check_count} = '0;
		{reg_addr, reg_wdata, local_sample} = '0;
		addr_sel_open = 1'b1;
		dither = 1'b1;
		temp = 11'h000;
		reset = 1'b1;
		tick(10);
		reset = 1'b0;
		tick(5);
		t_reset();
		t_remote();
		t_local();
		t_limits();
		t_overtemp();
		t_extpull();
		results();
	end
endmodule
`default_nettype wire
